// ===== verilog/smcr_pkg.sv
// Constants shared by the safety monitor configuration block
`default_nettype none
package smcr_pkg;
    localparam int CLK_MHZ = 100;
    localparam int PWM_UNIT_US = 15;
    localparam int ALT_UNIT_US = 5;
    localparam int PWM_UNIT_CYC = PWM_UNIT_US * CLK_MHZ;
    localparam int ALT_UNIT_CYC = ALT_UNIT_US * CLK_MHZ;
    localparam int CYC_W = 19;
    localparam logic [7:0] OFS_HMIN = 8'h00;
    localparam logic [7:0] OFS_LMAX = 8'h04;
    localparam logic [7:0] OFS_LMIN = 8'h08;
    localparam logic [7:0] OFS_PWD = 8'h0c;
    localparam logic [7:0] OFS_CRC = 8'h10;
    localparam logic [7:0] OFS_HMAX = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] HMIN_RST = 8'ha7;
    localparam logic [7:0] HMAX_RST = 8'ha8;
    localparam logic [7:0] LMAX_RST = 8'h3d;
    localparam logic [7:0] LMIN_RST = 8'h3c;
    localparam logic [3:0] POWERDOWN_THRESHOLD_RST = 4'hf;
    localparam logic PWD_EN_RST = 1'b0;
    localparam logic [7:0] CRC_RST = 8'h96;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam int PWD_EN_BIT = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_LOCK_BIT = 2;
    localparam int ST_HIGH_BIT = 0;
    localparam int ST_LOW_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_PWD_BIT = 3;
endpackage
`default_nettype wire

// ===== verilog/smcr_bound_if.sv
// Phase bounds in clock cycles passed from the converter to the monitor
`timescale 1ns/1ps
`default_nettype none
interface smcr_bound_if;
    logic [smcr_pkg::CYC_W-1:0] high_min;
    logic [smcr_pkg::CYC_W-1:0] high_max;
    logic [smcr_pkg::CYC_W-1:0] low_min;
    logic [smcr_pkg::CYC_W-1:0] low_max;
    logic enable;
    logic mode;
    modport src (output high_min, output high_max, output low_min,
        output low_max, output enable, output mode);
    modport dst (input high_min, input high_max, input low_min,
        input low_max, input enable, input mode);
endinterface
`default_nettype wire

// ===== verilog/smcr_bound_calc.sv
// Converts register fields into phase bounds counted in clock cycles
`timescale 1ns/1ps
`default_nettype none
module smcr_bound_calc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] high_min_count,
    input wire logic [7:0] high_max_count,
    input wire logic [7:0] low_min_count,
    input wire logic [7:0] low_max_count,
    input wire logic error_monitor_enable,
    input wire logic monitor_mode_select,
    smcr_bound_if.src bus
);
    localparam int W = smcr_pkg::CYC_W;

    function automatic logic [W-1:0] to_cycles(input logic [7:0] f,
        input int unit);
        logic [W-1:0] u;
        u = W'(unit);
        return W'(({11'h000, f} + 19'h0_0001) * u);
    endfunction

    logic [W-1:0] hmin_d, hmax_d, lmin_d, lmax_d;

    always_comb begin
        hmin_d = to_cycles(high_min_count, smcr_pkg::PWM_UNIT_CYC);
        hmax_d = to_cycles(high_max_count, smcr_pkg::PWM_UNIT_CYC);
        lmin_d = to_cycles(low_min_count, smcr_pkg::PWM_UNIT_CYC);
        if (monitor_mode_select) begin
            lmax_d = to_cycles(low_max_count, smcr_pkg::PWM_UNIT_CYC);
        end else begin
            lmax_d = to_cycles(low_max_count, smcr_pkg::ALT_UNIT_CYC);
        end
    end

    // Products are registered so the monitor compares against stable values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.high_min <= '0;
            bus.high_max <= '0;
            bus.low_min <= '0;
            bus.low_max <= '0;
            bus.enable <= 1'b0;
            bus.mode <= 1'b0;
        end else begin
            bus.high_min <= hmin_d;
            bus.high_max <= hmax_d;
            bus.low_min <= lmin_d;
            bus.low_max <= lmax_d;
            bus.enable <= error_monitor_enable;
            bus.mode <= monitor_mode_select;
        end
    end

    // Sampled reset keeps the releasing edge from starting an attempt
    a_high_min_time: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> bus.high_min == 19'(($past(high_min_count) + 19'h0_0001)
            * 19'h0_05dc))
        else $error("high min bound not 15 us per step");
    a_low_max_pwm: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn && monitor_mode_select |=> bus.low_max ==
            19'(($past(low_max_count) + 19'h0_0001) * 19'h0_05dc))
        else $error("low max bound not 15 us per step");
    a_low_max_alt: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn && !monitor_mode_select |=> bus.low_max ==
            19'(($past(low_max_count) + 19'h0_0001) * 19'h0_01f4))
        else $error("low max bound not 5 us per step");
    a_low_min_time: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> bus.low_min == 19'(($past(low_min_count) + 19'h0_0001)
            * 19'h0_05dc))
        else $error("low min bound not 15 us per step");
endmodule // smcr_bound_calc
`default_nettype wire

// ===== verilog/smcr_phase_mon.sv
// Measures high and low phases of the error pin against the bounds
`timescale 1ns/1ps
`default_nettype none
module smcr_phase_mon (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic error_pin,
    smcr_bound_if.dst bus,
    output logic high_err,
    output logic low_err
);
    localparam int W = smcr_pkg::CYC_W;
    logic sync1_q, level_q, prev_q;
    logic [W-1:0] cnt_q, cnt_d;
    logic hi_d, lo_d, edge_seen;

    always_comb begin
        edge_seen = level_q != prev_q;
        hi_d = 1'b0;
        lo_d = 1'b0;
        if (edge_seen) begin
            cnt_d = 19'h0_0001;
        end else if (cnt_q != {W{1'b1}}) begin
            cnt_d = cnt_q + 19'h0_0001;
        end else begin
            cnt_d = cnt_q;
        end
        if (bus.enable) begin
            if (edge_seen) begin
                // Phase just ended; minimum bounds apply in PWM mode only
                hi_d = bus.mode && prev_q && cnt_q < bus.high_min;
                lo_d = bus.mode && !prev_q && cnt_q < bus.low_min;
            end else begin
                // Fires once, the cycle the phase outgrows its maximum
                hi_d = bus.mode && level_q && cnt_q == bus.high_max;
                lo_d = !level_q && cnt_q == bus.low_max;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b1;
            level_q <= 1'b1;
            prev_q <= 1'b1;
            cnt_q <= '0;
            high_err <= 1'b0;
            low_err <= 1'b0;
        end else begin
            sync1_q <= error_pin;
            level_q <= sync1_q;
            prev_q <= level_q;
            cnt_q <= cnt_d;
            high_err <= hi_d;
            low_err <= lo_d;
        end
    end

    a_monitor_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !bus.enable |=> !high_err && !low_err)
        else $error("monitor flagged while disabled");
    a_low_overrun: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus.enable && !level_q && !edge_seen && cnt_q == bus.low_max
        |=> low_err)
        else $error("low phase overrun not flagged");
    a_high_short: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus.enable && bus.mode && edge_seen && prev_q
        && cnt_q < bus.high_min |=> high_err)
        else $error("short high phase not flagged");
endmodule // smcr_phase_mon
`default_nettype wire

// ===== verilog/smcr_top.sv
// Safety monitor configuration registers with APB access
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - In PWM mode the shortest high phase is (high min field + 1) x 15 us.
// - Mode select 1: longest low phase is (low max field + 1) x 15 us.
// - Mode select 0: longest low phase is (low max field + 1) x 5 us.
// - In PWM mode the shortest low phase is (low min field + 1) x 15 us.
// - Bound, powerdown and checksum writes land only in the diagnostic state with the lock clear.
// - With powerdown enable set, counter equal to threshold requests OFF.
// - The 4-bit threshold sits in bits 3..0, resets to all ones.
// - An 8-bit expected configuration checksum is stored for software.
// - The checksum resets to the value matching the default configuration.
// - The error signal monitor runs only while its enable bit is 1.
module smcr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic error_pin,
    input wire logic diag_state,
    input wire logic [3:0] device_error_counter,
    output logic irq,
    output logic off_request
);
    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {smcr_pkg::OFS_HMIN, smcr_pkg::OFS_LMAX,
            smcr_pkg::OFS_LMIN, smcr_pkg::OFS_PWD, smcr_pkg::OFS_CRC,
            smcr_pkg::OFS_HMAX, smcr_pkg::OFS_CTRL, smcr_pkg::OFS_STATUS,
            smcr_pkg::OFS_MASK};
    endfunction

    function automatic logic is_guarded(input logic [7:0] a);
        return a inside {smcr_pkg::OFS_HMIN, smcr_pkg::OFS_LMAX,
            smcr_pkg::OFS_LMIN, smcr_pkg::OFS_PWD, smcr_pkg::OFS_CRC,
            smcr_pkg::OFS_HMAX};
    endfunction

    logic [7:0] hmin_q, hmin_d, hmax_q, hmax_d;
    logic [7:0] lmax_q, lmax_d, lmin_q, lmin_d;
    logic [7:0] crc_q, crc_d;
    logic [3:0] th_q, th_d;
    logic pwd_en_q, pwd_en_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [3:0] status_q, status_d, mask_q, mask_d, events, clr;
    logic irq_d, off_d, pwd_match;
    logic pready_d, pslverr_d;
    logic [31:0] prdata_d, rdata;
    logic access, wr_ok, commit, refused;
    logic high_err, low_err;

    smcr_bound_if bnd ();

    smcr_bound_calc u_calc (
        .pclk(pclk),
        .presetn(presetn),
        .high_min_count(hmin_q),
        .high_max_count(hmax_q),
        .low_min_count(lmin_q),
        .low_max_count(lmax_q),
        .error_monitor_enable(ctrl_q[smcr_pkg::CTRL_EN_BIT]),
        .monitor_mode_select(ctrl_q[smcr_pkg::CTRL_MODE_BIT]),
        .bus(bnd.src)
    );

    smcr_phase_mon u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .error_pin(error_pin),
        .bus(bnd.dst),
        .high_err(high_err),
        .low_err(low_err)
    );

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr)
            smcr_pkg::OFS_HMIN: rdata[7:0] = hmin_q;
            smcr_pkg::OFS_LMAX: rdata[7:0] = lmax_q;
            smcr_pkg::OFS_LMIN: rdata[7:0] = lmin_q;
            smcr_pkg::OFS_PWD: rdata[4:0] = {pwd_en_q, th_q};
            smcr_pkg::OFS_CRC: rdata[7:0] = crc_q;
            smcr_pkg::OFS_HMAX: rdata[7:0] = hmax_q;
            smcr_pkg::OFS_CTRL: rdata[2:0] = ctrl_q;
            smcr_pkg::OFS_STATUS: rdata[3:0] = status_q;
            smcr_pkg::OFS_MASK: rdata[3:0] = mask_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // One wait state so every bus output leaves a flip-flop
    always_comb begin
        access = psel && penable;
        wr_ok = diag_state && !ctrl_q[smcr_pkg::CTRL_LOCK_BIT];
        pready_d = access && !pready;
        refused = pready_d && pwrite && is_guarded(paddr) && !wr_ok;
        pslverr_d = pready_d && (!is_mapped(paddr) || refused);
        prdata_d = (pready_d && !pwrite) ? rdata : 32'h0000_0000;
        commit = access && pready && pwrite && !pslverr;
    end

    always_comb begin
        hmin_d = hmin_q;
        hmax_d = hmax_q;
        lmax_d = lmax_q;
        lmin_d = lmin_q;
        crc_d = crc_q;
        th_d = th_q;
        pwd_en_d = pwd_en_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        clr = 4'h0;
        if (commit) begin
            unique case (paddr)
                smcr_pkg::OFS_HMIN: hmin_d = pwdata[7:0];
                smcr_pkg::OFS_LMAX: lmax_d = pwdata[7:0];
                smcr_pkg::OFS_LMIN: lmin_d = pwdata[7:0];
                smcr_pkg::OFS_PWD: begin
                    th_d = pwdata[3:0];
                    pwd_en_d = pwdata[smcr_pkg::PWD_EN_BIT];
                end
                smcr_pkg::OFS_CRC: crc_d = pwdata[7:0];
                smcr_pkg::OFS_HMAX: hmax_d = pwdata[7:0];
                smcr_pkg::OFS_CTRL: ctrl_d = pwdata[2:0];
                smcr_pkg::OFS_STATUS: clr = pwdata[3:0];
                smcr_pkg::OFS_MASK: mask_d = pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        pwd_match = pwd_en_q && device_error_counter == th_q;
        off_d = off_request || pwd_match;
        events = 4'h0;
        events[smcr_pkg::ST_HIGH_BIT] = high_err;
        events[smcr_pkg::ST_LOW_BIT] = low_err;
        events[smcr_pkg::ST_REFUSED_BIT] = refused;
        events[smcr_pkg::ST_PWD_BIT] = pwd_match && !off_request;
        // A new event outranks a clear landing in the same cycle
        status_d = (status_q & ~clr) | events;
        irq_d = |(status_d & mask_d);
    end

    // Power-on reset is the only initialisation source for these registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hmin_q <= smcr_pkg::HMIN_RST;
            hmax_q <= smcr_pkg::HMAX_RST;
            lmax_q <= smcr_pkg::LMAX_RST;
            lmin_q <= smcr_pkg::LMIN_RST;
            crc_q <= smcr_pkg::CRC_RST;
            th_q <= smcr_pkg::POWERDOWN_THRESHOLD_RST;
            pwd_en_q <= smcr_pkg::PWD_EN_RST;
            ctrl_q <= smcr_pkg::CTRL_RST;
            mask_q <= smcr_pkg::MASK_RST;
            status_q <= smcr_pkg::STATUS_RST;
            irq <= 1'b0;
            off_request <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            hmin_q <= hmin_d;
            hmax_q <= hmax_d;
            lmax_q <= lmax_d;
            lmin_q <= lmin_d;
            crc_q <= crc_d;
            th_q <= th_d;
            pwd_en_q <= pwd_en_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            status_q <= status_d;
            irq <= irq_d;
            off_request <= off_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            prdata <= prdata_d;
        end
    end

    // Helper: low during reset and in the first cycle after reset release
    logic seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    a_cfg_write_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(hmin_q) || $changed(lmax_q) || $changed(lmin_q)
        || $changed(crc_q) || $changed(th_q) || $changed(pwd_en_q)
        |-> $past(diag_state) && !$past(ctrl_q[smcr_pkg::CTRL_LOCK_BIT]))
        else $error("configuration changed outside unlocked diagnostic");
    a_locked_refused: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && is_guarded(paddr)
        && !wr_ok |=> pready && pslverr ##1 !pready)
        else $error("locked write not refused with an error");
    a_off_on_match: assert property (
        @(posedge pclk) disable iff (!presetn)
        pwd_en_q && device_error_counter == th_q |=> off_request)
        else $error("threshold match did not request OFF");
    a_off_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(off_request) |-> $past(pwd_en_q)
        && $past(device_error_counter) == $past(th_q))
        else $error("OFF requested without enabled match");
    a_threshold_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> th_q == 4'hf && !pwd_en_q)
        else $error("threshold reset value wrong");
    a_crc_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && paddr == smcr_pkg::OFS_CRC |=> crc_q == $past(pwdata[7:0]))
        else $error("checksum write not stored");
    a_crc_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> crc_q == 8'h96)
        else $error("checksum reset value wrong");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(status_q & mask_q))
        else $error("interrupt does not follow masked status");

    c_refused_write: cover property (@(posedge pclk) disable iff (!presetn)
        refused);
    c_low_overrun: cover property (@(posedge pclk) disable iff (!presetn)
        low_err && ctrl_q[smcr_pkg::CTRL_MODE_BIT] == 1'b0);
    c_powerdown: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(off_request));
endmodule // smcr_top
`default_nettype wire

// ===== tb/smcr_host_model.sv
// Host-side model driving the error signal pin
`timescale 1ns/1ps
`default_nettype none
module smcr_host_model (
    input wire logic pclk,
    output logic error_pin
);
    // The pin idles high between pulses, as the synchroniser assumes
    initial error_pin = 1'b1;
    // One low phase then one high phase, lengths in clock cycles
    task automatic pulse(input int low_cyc, input int high_cyc);
        @(posedge pclk);
        error_pin <= 1'b0;
        repeat (low_cyc) @(posedge pclk);
        error_pin <= 1'b1;
        repeat (high_cyc) @(posedge pclk);
    endtask
endmodule // smcr_host_model
`default_nettype wire

// ===== tb/smcr_top_test.sv
// Register, interrupt, powerdown and monitor tests for the config block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
end
module smcr_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire error_pin;
    logic diag_state = 1'b0;
    logic [3:0] device_error_counter = 4'h0;
    logic irq;
    logic off_request;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    smcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .error_pin(error_pin),
        .diag_state(diag_state),
        .device_error_counter(device_error_counter), .irq(irq),
        .off_request(off_request));

    smcr_host_model host (.pclk(pclk), .error_pin(error_pin));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Request stands until pready is seen high at a rising edge; the
    // answer is taken at that edge, before the design updates its outputs
    task automatic apb(input logic wr_en, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // One wait state: the answer stands at the second access edge
        `CHK("pready wait", 2, n)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic e);
        logic [31:0] r;
        logic s;
        apb(1'b1, a, {24'h00_0000, d}, r, s);
        `CHK("pslverr", e, s)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic s;
        apb(1'b0, a, 32'h0000_0000, r, s);
        `CHK("prdata", exp, r)
    endtask

    // Registered flags follow their cause one edge later
    task automatic settle;
        repeat (2) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] r;
        logic s;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(smcr_pkg::OFS_HMIN, 32'h0000_00a7);
        rd_chk(smcr_pkg::OFS_LMAX, 32'h0000_003d);
        rd_chk(smcr_pkg::OFS_LMIN, 32'h0000_003c);
        rd_chk(smcr_pkg::OFS_PWD, 32'h0000_000f);
        rd_chk(smcr_pkg::OFS_CRC, 32'h0000_0096);
        rd_chk(smcr_pkg::OFS_CTRL, 32'h0000_0000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0000);
        $display("test reset values done");

        wr(smcr_pkg::OFS_CRC, 8'h5a, 1'b1);
        rd_chk(smcr_pkg::OFS_CRC, 32'h0000_0096);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0004);
        diag_state <= 1'b1;
        wr(smcr_pkg::OFS_CRC, 8'h5a, 1'b0);
        rd_chk(smcr_pkg::OFS_CRC, 32'h0000_005a);
        wr(smcr_pkg::OFS_CTRL, 8'h04, 1'b0);
        wr(smcr_pkg::OFS_HMIN, 8'h11, 1'b1);
        rd_chk(smcr_pkg::OFS_HMIN, 32'h0000_00a7);
        wr(smcr_pkg::OFS_CTRL, 8'h00, 1'b0);
        apb(1'b0, 8'h40, 32'h0000_0000, r, s);
        `CHK("unmapped pslverr", 1'b1, s)
        `CHK("unmapped prdata", 32'h0000_0000, r)
        $display("test write gating done");

        settle();
        `CHK("irq", 1'b0, irq)
        wr(smcr_pkg::OFS_MASK, 8'h04, 1'b0);
        settle();
        `CHK("irq", 1'b1, irq)
        wr(smcr_pkg::OFS_STATUS, 8'h04, 1'b0);
        settle();
        `CHK("irq", 1'b0, irq)
        $display("test interrupt done");

        device_error_counter <= 4'h3;
        wr(smcr_pkg::OFS_PWD, 8'h03, 1'b0);
        settle();
        `CHK("off_request", 1'b0, off_request)
        device_error_counter <= 4'h2;
        wr(smcr_pkg::OFS_PWD, 8'h13, 1'b0);
        settle();
        `CHK("off_request", 1'b0, off_request)
        device_error_counter <= 4'h3;
        settle();
        settle();
        `CHK("off_request", 1'b1, off_request)
        rd_chk(smcr_pkg::OFS_PWD, 32'h0000_0013);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0008);
        device_error_counter <= 4'h0;
        $display("test powerdown done");

        // Wide high maximum keeps idle-high stretches from flagging
        wr(smcr_pkg::OFS_HMAX, 8'hff, 1'b0);
        wr(smcr_pkg::OFS_LMAX, 8'h01, 1'b0);
        wr(smcr_pkg::OFS_LMIN, 8'h00, 1'b0);
        wr(smcr_pkg::OFS_HMIN, 8'h00, 1'b0);
        wr(smcr_pkg::OFS_STATUS, 8'h0f, 1'b0);
        host.pulse(2000, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0000);
        wr(smcr_pkg::OFS_CTRL, 8'h01, 1'b0);
        host.pulse(950, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0000);
        host.pulse(1050, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0002);
        wr(smcr_pkg::OFS_STATUS, 8'h0f, 1'b0);
        wr(smcr_pkg::OFS_CTRL, 8'h03, 1'b0);
        host.pulse(2000, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0000);
        host.pulse(3050, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0002);
        wr(smcr_pkg::OFS_STATUS, 8'h0f, 1'b0);
        host.pulse(1450, 1000);
        host.pulse(2000, 2000);
        rd_chk(smcr_pkg::OFS_STATUS, 32'h0000_0003);
        $display("test phase monitor done");
        give_verdict();
    end
endmodule // smcr_top_test
`default_nettype wire
